// >>> pin_remap_pkg.sv
// Shared constants for the peripheral pin remapping matrix.
package pin_remap_pkg;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;
    localparam int NUM_IN = 24;
    localparam int NUM_PINS = 32;
    localparam int GROUP_PINS = 8;
    localparam int NUM_GROUPS = 4;
    localparam int NUM_PO = 11;
    localparam int NUM_WORDS = NUM_IN + NUM_PINS;
    localparam int IDX_W = 6;

    // Register map, byte addresses.
    localparam logic [ADDR_W-1:0] IN_SEL_BASE = 12'h000;
    localparam logic [ADDR_W-1:0] IN_SEL_END = 12'h060;
    localparam logic [ADDR_W-1:0] OUT_SEL_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] OUT_SEL_END = 12'h180;
    localparam logic [ADDR_W-1:0] CFG_CTRL_OFFSET = 12'h200;
    localparam logic [ADDR_W-1:0] DEV_CFG_OFFSET = 12'h204;
    localparam logic [ADDR_W-1:0] UNLOCK_KEY_OFFSET = 12'h208;

    localparam int LOCK_BIT = 13;
    localparam int FUSE_BIT = 29;
    localparam logic LOCK_RESET = 1'b0;
    localparam logic FUSE_RESET = 1'b1;
    localparam logic [SEL_W-1:0] SEL_RESET = 4'h0;

    // Unlock key values are arbitrary.
    localparam logic [DATA_W-1:0] KEY_FIRST = 32'h5A5AC3C3;
    localparam logic [DATA_W-1:0] KEY_SECOND = 32'hC3C35A5A;

    typedef enum {KEY_IDLE, KEY_HALF, KEY_OPEN} key_state_e;

    // Peripheral input index order: ext_irq4_in, timer2_clock_in, capture4_in, spi1_select, ref_clock_in,
    // ext_irq3_in, timer3_clock_in, capture3_in, uart1_clear_to_send_in, uart2_receive_in, spi1_data_in,
    // ext_irq2_in, timer4_clock_in, capture1_in, capture5_in, uart1_receive_in, uart2_clear_to_send_in,
    // spi2_data_in, compare_fault_b_in, ext_irq1_in, timer5_clock_in, capture2_in, spi2_select,
    // compare_fault_a_in.
    localparam logic [1:0] IN_GROUP [NUM_IN] = '{
        2'h0, 2'h0, 2'h0, 2'h0, 2'h0,
        2'h1, 2'h1, 2'h1, 2'h1, 2'h1, 2'h1,
        2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2, 2'h2,
        2'h3, 2'h3, 2'h3, 2'h3, 2'h3};

    // Selects and uart lines idle high, everything else idles low.
    localparam logic [NUM_IN-1:0] IN_IDLE = 24'h418308;

    // Peripheral output indices.
    localparam logic [3:0] PO_SPI1_SEL = 4'h0;
    localparam logic [3:0] PO_SPI1_DATA = 4'h1;
    localparam logic [3:0] PO_SPI2_DATA = 4'h2;
    localparam logic [3:0] PO_SPI2_SEL = 4'h3;
    localparam logic [3:0] PO_CMP2 = 4'h4;
    localparam logic [3:0] PO_CMP3 = 4'h5;
    localparam logic [3:0] PO_CMP4 = 4'h6;
    localparam logic [3:0] PO_CMP5 = 4'h7;
    localparam logic [3:0] PO_COMPARATOR1 = 4'h8;
    localparam logic [3:0] PO_COMPARATOR2 = 4'h9;
    localparam logic [3:0] PO_REF_CLK = 4'hA;
    localparam logic [3:0] PO_NONE = 4'hF;

    // Output code to peripheral output, one row per pin group.
    localparam logic [3:0] OUT_MAP [NUM_GROUPS][16] = '{
        '{PO_NONE, PO_NONE, PO_NONE, PO_SPI1_SEL, PO_NONE, PO_NONE, PO_NONE, PO_COMPARATOR2,
          PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE},
        '{PO_NONE, PO_NONE, PO_NONE, PO_SPI1_DATA, PO_SPI2_DATA, PO_CMP2, PO_NONE, PO_NONE,
          PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE},
        '{PO_NONE, PO_NONE, PO_NONE, PO_SPI1_DATA, PO_SPI2_DATA, PO_CMP4, PO_CMP5, PO_REF_CLK,
          PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE},
        '{PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_SPI2_SEL, PO_CMP3, PO_NONE, PO_COMPARATOR1,
          PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE, PO_NONE}};

endpackage

// >>> selector_store.sv
// Bank of 4-bit selector fields with one write port and a registered read port.
`timescale 1ns/1ps
module selector_store
#(
    parameter int WORDS = 56,
    parameter int WIDTH = 4,
    parameter int IDX_W = 6
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic we,
    input wire logic [IDX_W-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wdata,
    input wire logic [IDX_W-1:0] rd_idx,
    output logic [WIDTH-1:0] rdata,
    output logic [WORDS*WIDTH-1:0] fields
);

    logic [WIDTH-1:0] rdata_q;
    logic [WIDTH-1:0] rdata_d;

    // Every field is visible at once because each one steers a mux continuously.
    for (genvar gw = 0; gw < WORDS; gw++)
    begin : g_word
        logic [WIDTH-1:0] word_q;
        logic [WIDTH-1:0] word_d;

        always_comb
        begin
            word_d = word_q;
            if (we && (wr_idx == IDX_W'(gw)))
            begin
                word_d = wdata;
            end
        end

        always_ff @(posedge clk or negedge arst_n)
        begin
            if (!arst_n)
            begin
                word_q <= '0;
            end
            else
            begin
                word_q <= word_d;
            end
        end

        assign fields[gw*WIDTH +: WIDTH] = word_q;
    end

    always_comb
    begin
        rdata_d = '0;
        if (int'(rd_idx) < WORDS)
        begin
            rdata_d = fields[int'(rd_idx)*WIDTH +: WIDTH];
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata_q <= '0;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

endmodule

// >>> peripheral_pin_remap.sv
// Peripheral pin remapping matrix with APB selector registers and write lock.
//
// Behaviour
// R01: Each peripheral input chooses its own source pin.
// R02: Input selector fields are four bits each.
// R03: First input group maps codes 0-7 to its pins.
// R04: Second input group maps codes 0-7 to pins.
// R05: Third input group maps codes 0-7 to pins.
// R06: Fourth input group maps codes 0-7 to pins.
// R07: Each pin chooses its peripheral output by field.
// R08: Output code zero and reset connect nothing.
// R09: First pin group: spi1 select, comparator 2.
// R10: Second pin group: spi1, spi2 data, compare 2.
// R11: Third pin group: spi data, compares, reference clock.
// R12: Fourth pin group: spi2 select, compare 3, comparator 1.
// R13: Lock discards selector writes, transfer still completes.
// R14: Lock is config control bit 13.
// R15: Software unlocks with key sequence before changing lock.
// R16: Fuse bit 29 stops lock clearing once set.
// R17: Fused lock ignores unlock, selectors stay frozen.
// R18: Only device reset clears a fused lock.
// R19: Unprogrammed fuse reads set, one session allowed.
// R20: Input selectors: bits 3:0 read/write, rest zero.
// R21: Remap beats digital pin functions, never analog.
// R22: Reserved codes act as no connection.
`timescale 1ns/1ps
module peripheral_pin_remap
import pin_remap_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic FUSE_CONFIG_BIT,
    input wire logic [NUM_PINS-1:0] PIN_IN,
    input wire logic [NUM_PINS-1:0] PIN_ANALOG,
    output logic [NUM_PINS-1:0] PIN_OUT,
    output logic [NUM_PINS-1:0] PIN_REMAP_N,
    input wire logic SPI1_SELECT_OUT,
    input wire logic SPI1_DATA_OUT,
    input wire logic SPI2_DATA_OUT,
    input wire logic SPI2_SELECT_OUT,
    input wire logic COMPARE2_OUT,
    input wire logic COMPARE3_OUT,
    input wire logic COMPARE4_OUT,
    input wire logic COMPARE5_OUT,
    input wire logic COMPARATOR1_RESULT_OUT,
    input wire logic COMPARATOR2_RESULT_OUT,
    input wire logic REF_CLOCK_OUT,
    output logic EXT_IRQ4_IN,
    output logic TIMER2_CLOCK_IN,
    output logic CAPTURE4_IN,
    output logic SPI1_SELECT_IN,
    output logic REF_CLOCK_IN,
    output logic EXT_IRQ3_IN,
    output logic TIMER3_CLOCK_IN,
    output logic CAPTURE3_IN,
    output logic UART1_CLEAR_TO_SEND_IN,
    output logic UART2_RECEIVE_IN,
    output logic SPI1_DATA_IN,
    output logic EXT_IRQ2_IN,
    output logic TIMER4_CLOCK_IN,
    output logic CAPTURE1_IN,
    output logic CAPTURE5_IN,
    output logic UART1_RECEIVE_IN,
    output logic UART2_CLEAR_TO_SEND_IN,
    output logic SPI2_DATA_IN,
    output logic COMPARE_FAULT_B_IN,
    output logic EXT_IRQ1_IN,
    output logic TIMER5_CLOCK_IN,
    output logic CAPTURE2_IN,
    output logic SPI2_SELECT_IN,
    output logic COMPARE_FAULT_A_IN
);

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    logic [NUM_PINS-1:0] pin_s1_q;
    logic [NUM_PINS-1:0] pin_s2_q;
    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [DATA_W-1:0] prdata_q;
    logic [DATA_W-1:0] prdata_d;
    logic mapping_write_lock_q;
    logic mapping_write_lock_d;
    logic single_session_fuse_q;
    logic single_session_fuse_d;
    logic fuse_taken_q;
    logic fuse_taken_d;
    key_state_e key_q;
    key_state_e key_d;
    logic [NUM_IN-1:0] periph_in_q;
    logic [NUM_IN-1:0] periph_in_d;
    logic [NUM_PINS-1:0] pin_out_q;
    logic [NUM_PINS-1:0] pin_out_d;
    logic [NUM_PINS-1:0] pin_remap_n_q;
    logic [NUM_PINS-1:0] pin_remap_n_d;
    logic hit_in;
    logic hit_out;
    logic hit_cfg;
    logic hit_dev;
    logic hit_key;
    logic mapped;
    logic xfer;
    logic wr;
    logic sel_we;
    logic lock_held;
    logic [IDX_W-1:0] sel_idx;
    logic [SEL_W-1:0] sel_rdata;
    logic [NUM_WORDS*SEL_W-1:0] sel_fields;
    logic [DATA_W-1:0] rd_word;
    logic [15:0] periph_out;

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Pin synchroniser. Only the second stage feeds the input muxes.

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end
        else
        begin
            pin_s1_q <= PIN_IN;
            pin_s2_q <= pin_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // APB decode. Each selector occupies one aligned word.

    assign hit_in = (PADDR >= IN_SEL_BASE) && (PADDR < IN_SEL_END) && (PADDR[1:0] == 2'h0);
    assign hit_out = (PADDR >= OUT_SEL_BASE) && (PADDR < OUT_SEL_END) && (PADDR[1:0] == 2'h0);
    assign hit_cfg = (PADDR == CFG_CTRL_OFFSET);
    assign hit_dev = (PADDR == DEV_CFG_OFFSET);
    assign hit_key = (PADDR == UNLOCK_KEY_OFFSET);
    assign mapped = hit_in | hit_out | hit_cfg | hit_dev | hit_key;
    assign xfer = PSEL & PENABLE & pready_q;
    assign wr = xfer & PWRITE & mapped;
    assign lock_held = mapping_write_lock_q & single_session_fuse_q;
    // Locked writes still complete with OKAY; they only fail to store.
    assign sel_we = wr & (hit_in | hit_out) & ~mapping_write_lock_q; // R13

    always_comb
    begin
        sel_idx = '0;
        if (hit_in)
        begin
            sel_idx = IDX_W'(PADDR[ADDR_W-1:2] - IN_SEL_BASE[ADDR_W-1:2]);
        end
        else if (hit_out)
        begin
            sel_idx = IDX_W'(PADDR[ADDR_W-1:2] - OUT_SEL_BASE[ADDR_W-1:2] + NUM_IN);
        end
    end

    selector_store #(
        .WORDS(NUM_WORDS),
        .WIDTH(SEL_W),
        .IDX_W(IDX_W)
    ) u_store (
        .clk(REF_CLK),
        .arst_n(ARST_N),
        .we(sel_we),
        .wr_idx(sel_idx),
        .wdata(PWDATA[SEL_W-1:0]),
        .rd_idx(sel_idx),
        .rdata(sel_rdata),
        .fields(sel_fields)
    );

    always_comb
    begin
        rd_word = '0;
        if (hit_in || hit_out)
        begin
            rd_word[SEL_W-1:0] = sel_rdata; // R20
        end
        else if (hit_cfg)
        begin
            rd_word[LOCK_BIT] = mapping_write_lock_q; // R14
        end
        else if (hit_dev)
        begin
            rd_word[FUSE_BIT] = single_session_fuse_q; // R19
        end
    end

    // One wait state lets the store's registered read data settle before the answer.
    always_comb
    begin
        pready_d = PSEL & PENABLE & ~pready_q;
        prdata_d = prdata_q;
        pslverr_d = 1'b0;
        if (pready_d)
        begin
            prdata_d = rd_word;
            pslverr_d = ~mapped;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            pready_q <= 1'b0;
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            pready_q <= pready_d;
            prdata_q <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Lock, fuse and unlock sequence.

    always_comb
    begin
        key_d = key_q;
        mapping_write_lock_d = mapping_write_lock_q;
        single_session_fuse_d = single_session_fuse_q;
        fuse_taken_d = 1'b1;
        if (!fuse_taken_q)
        begin
            single_session_fuse_d = FUSE_CONFIG_BIT; // R19
        end
        if (wr)
        begin
            key_d = KEY_IDLE;
            if (hit_key && !lock_held) // R17
            begin
                if (PWDATA == KEY_FIRST)
                begin
                    key_d = KEY_HALF;
                end
                else if ((key_q == KEY_HALF) && (PWDATA == KEY_SECOND))
                begin
                    key_d = KEY_OPEN;
                end
            end
            // Without the key sequence a write to the control word leaves the lock alone.
            if (hit_cfg && (key_q == KEY_OPEN) && !lock_held) // R15 R16
            begin
                mapping_write_lock_d = PWDATA[LOCK_BIT]; // R14
            end
        end
    end

    // A fused lock has no release path here; only the asynchronous reset clears it.
    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            key_q <= KEY_IDLE;
            mapping_write_lock_q <= LOCK_RESET; // R18
            single_session_fuse_q <= FUSE_RESET;
            fuse_taken_q <= 1'b0;
        end
        else
        begin
            key_q <= key_d;
            mapping_write_lock_q <= mapping_write_lock_d;
            single_session_fuse_q <= single_session_fuse_d;
            fuse_taken_q <= fuse_taken_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Input mapping: one 4-bit field per peripheral input picks a pin of its group.

    for (genvar gi = 0; gi < NUM_IN; gi++)
    begin : g_in
        logic [SEL_W-1:0] code;
        logic [4:0] pin;

        assign code = sel_fields[gi*SEL_W +: SEL_W]; // R02
        assign pin = {IN_GROUP[gi], code[2:0]}; // R03 R04 R05 R06

        always_comb
        begin
            if (!code[SEL_W-1] && !PIN_ANALOG[pin]) // R21 R22
            begin
                periph_in_d[gi] = pin_s2_q[pin]; // R01
            end
            else
            begin
                periph_in_d[gi] = IN_IDLE[gi]; // R22
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Output mapping: one 4-bit field per pin picks a peripheral output.

    assign periph_out = {5'h00, REF_CLOCK_OUT, COMPARATOR2_RESULT_OUT, COMPARATOR1_RESULT_OUT,
        COMPARE5_OUT, COMPARE4_OUT, COMPARE3_OUT, COMPARE2_OUT, SPI2_SELECT_OUT, SPI2_DATA_OUT,
        SPI1_DATA_OUT, SPI1_SELECT_OUT};

    for (genvar gp = 0; gp < NUM_PINS; gp++)
    begin : g_out
        logic [SEL_W-1:0] code;
        logic [3:0] src;
        logic active;

        assign code = sel_fields[(NUM_IN + gp)*SEL_W +: SEL_W]; // R07
        // Code zero and every reserved code map to no source.
        assign src = OUT_MAP[gp / GROUP_PINS][code]; // R08 R09 R10 R11 R12 R22
        // An analog pin is never claimed, so remapped drive cannot fight the converter.
        assign active = (src != PO_NONE) && !PIN_ANALOG[gp]; // R21

        always_comb
        begin
            pin_out_d[gp] = active & periph_out[src];
            pin_remap_n_d[gp] = ~active;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            periph_in_q <= IN_IDLE;
            pin_out_q <= '0;
            pin_remap_n_q <= '1; // R08
        end
        else
        begin
            periph_in_q <= periph_in_d;
            pin_out_q <= pin_out_d;
            pin_remap_n_q <= pin_remap_n_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign PIN_OUT = pin_out_q;
    assign PIN_REMAP_N = pin_remap_n_q;
    assign EXT_IRQ4_IN = periph_in_q[0];
    assign TIMER2_CLOCK_IN = periph_in_q[1];
    assign CAPTURE4_IN = periph_in_q[2];
    assign SPI1_SELECT_IN = periph_in_q[3];
    assign REF_CLOCK_IN = periph_in_q[4];
    assign EXT_IRQ3_IN = periph_in_q[5];
    assign TIMER3_CLOCK_IN = periph_in_q[6];
    assign CAPTURE3_IN = periph_in_q[7];
    assign UART1_CLEAR_TO_SEND_IN = periph_in_q[8];
    assign UART2_RECEIVE_IN = periph_in_q[9];
    assign SPI1_DATA_IN = periph_in_q[10];
    assign EXT_IRQ2_IN = periph_in_q[11];
    assign TIMER4_CLOCK_IN = periph_in_q[12];
    assign CAPTURE1_IN = periph_in_q[13];
    assign CAPTURE5_IN = periph_in_q[14];
    assign UART1_RECEIVE_IN = periph_in_q[15];
    assign UART2_CLEAR_TO_SEND_IN = periph_in_q[16];
    assign SPI2_DATA_IN = periph_in_q[17];
    assign COMPARE_FAULT_B_IN = periph_in_q[18];
    assign EXT_IRQ1_IN = periph_in_q[19];
    assign TIMER5_CLOCK_IN = periph_in_q[20];
    assign CAPTURE2_IN = periph_in_q[21];
    assign SPI2_SELECT_IN = periph_in_q[22];
    assign COMPARE_FAULT_A_IN = periph_in_q[23];

endmodule

// >>> pin_remap_props.sv
// Checker for the bus answer and pin drive relations of the pin remapping matrix.
`timescale 1ns/1ps
module pin_remap_props
import pin_remap_pkg::*;
(
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [DATA_W-1:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [NUM_PINS-1:0] PIN_ANALOG,
    input wire logic [NUM_PINS-1:0] PIN_OUT,
    input wire logic [NUM_PINS-1:0] PIN_REMAP_N
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!ARST_N);

    ////////////////////////////////////////////////////////////////////////////////
    AST_READY_ONE: assert property (PREADY |=> !PREADY)
        else $error("ready stood longer than one cycle");
    AST_READY_LATE: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY)
        else $error("ready not in second access cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
        else $error("error flag outside a completing transfer");
    AST_SEL_NO_ERR: assert property (PREADY && (PADDR < IN_SEL_END
        || (PADDR >= OUT_SEL_BASE && PADDR < OUT_SEL_END)) |-> !PSLVERR)
        else $error("selector access answered with error");
    AST_IN_UPPER_ZERO: assert property (PREADY && !PWRITE && PADDR < IN_SEL_END |-> PRDATA[31:4] == '0)
        else $error("input selector upper bits not zero");
    AST_NO_DRIVE_NO_OUT: assert property ((PIN_OUT & PIN_REMAP_N) == '0)
        else $error("pin level set on a pin that is not remapped");
    AST_ANALOG_FREE: assert property (1'b1 |=> (~PIN_REMAP_N & $past(PIN_ANALOG)) == '0)
        else $error("remap drives an analog pin");
    AST_ANALOG_LOW: assert property (1'b1 |=> (PIN_OUT & $past(PIN_ANALOG)) == '0)
        else $error("pin level set on an analog pin");
endmodule

bind peripheral_pin_remap pin_remap_props i_props (.REF_CLK, .ARST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
    .PRDATA, .PREADY, .PSLVERR, .PIN_ANALOG, .PIN_OUT, .PIN_REMAP_N);

// >>> board_pins.sv
// Board model: external levels on the remappable pins.
`timescale 1ns/1ps
module board_pins
(
    input wire logic [31:0] level,
    input wire logic [31:0] remap_n,
    input wire logic [31:0] pin_out,
    output logic [31:0] pin_in
);
    // The board drives weakly, so a pin the device drives reads back the device level.
    assign pin_in = (level & remap_n) | (pin_out & ~remap_n);
endmodule

// >>> tb.sv
// Self-checking bench for the peripheral pin remapping matrix.
`timescale 1ns/1ps
module tb
import pin_remap_pkg::*;
;
    logic REF_CLK = 0, ARST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, FUSE_CONFIG_BIT = 1;
    logic [ADDR_W-1:0] PADDR = '0;
    logic [DATA_W-1:0] PWDATA = '0, PRDATA, rd;
    logic PREADY, PSLVERR, er;
    logic [NUM_PINS-1:0] PIN_IN, PIN_ANALOG = '0, PIN_OUT, PIN_REMAP_N, level = '0;
    logic [10:0] po = '0;
    wire [23:0] psi;
    int err_total = 0, total_checks = 0;

    always #4 REF_CLK = ~REF_CLK;

    peripheral_pin_remap i_dut (.REF_CLK(REF_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
        .FUSE_CONFIG_BIT(FUSE_CONFIG_BIT), .PIN_IN(PIN_IN), .PIN_ANALOG(PIN_ANALOG), .PIN_OUT(PIN_OUT),
        .PIN_REMAP_N(PIN_REMAP_N), .SPI1_SELECT_OUT(po[0]), .SPI1_DATA_OUT(po[1]), .SPI2_DATA_OUT(po[2]),
        .SPI2_SELECT_OUT(po[3]), .COMPARE2_OUT(po[4]), .COMPARE3_OUT(po[5]), .COMPARE4_OUT(po[6]),
        .COMPARE5_OUT(po[7]), .COMPARATOR1_RESULT_OUT(po[8]), .COMPARATOR2_RESULT_OUT(po[9]),
        .REF_CLOCK_OUT(po[10]), .EXT_IRQ4_IN(psi[0]), .TIMER2_CLOCK_IN(psi[1]), .CAPTURE4_IN(psi[2]),
        .SPI1_SELECT_IN(psi[3]), .REF_CLOCK_IN(psi[4]), .EXT_IRQ3_IN(psi[5]), .TIMER3_CLOCK_IN(psi[6]),
        .CAPTURE3_IN(psi[7]), .UART1_CLEAR_TO_SEND_IN(psi[8]), .UART2_RECEIVE_IN(psi[9]),
        .SPI1_DATA_IN(psi[10]), .EXT_IRQ2_IN(psi[11]), .TIMER4_CLOCK_IN(psi[12]), .CAPTURE1_IN(psi[13]),
        .CAPTURE5_IN(psi[14]), .UART1_RECEIVE_IN(psi[15]), .UART2_CLEAR_TO_SEND_IN(psi[16]),
        .SPI2_DATA_IN(psi[17]), .COMPARE_FAULT_B_IN(psi[18]), .EXT_IRQ1_IN(psi[19]),
        .TIMER5_CLOCK_IN(psi[20]), .CAPTURE2_IN(psi[21]), .SPI2_SELECT_IN(psi[22]),
        .COMPARE_FAULT_A_IN(psi[23]));

    board_pins i_board (.level(level), .remap_n(PIN_REMAP_N), .pin_out(PIN_OUT), .pin_in(PIN_IN));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop;
        $display("checks=%0d errors=%0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge REF_CLK);
    endtask

    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        @(posedge REF_CLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        n = 0;
        do
        begin
            @(posedge REF_CLK);
            n++;
        end
        while (PREADY !== 1'b1 && n < 16);
        if (PREADY !== 1'b1)
        begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, PREADY, 1'b1);
            report_and_stop;
        end
        else
        begin
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    task automatic do_reset;
        ARST_N <= 1'b0;
        cyc(10);
        ARST_N <= 1'b1;
    endtask

    task automatic set_lock(input logic v);
        apb(1'b1, UNLOCK_KEY_OFFSET, KEY_FIRST);
        apb(1'b1, UNLOCK_KEY_OFFSET, KEY_SECOND);
        apb(1'b1, CFG_CTRL_OFFSET, 32'(v) << LOCK_BIT);
    endtask

    // Peripheral index in the order of po, or -1 where the code connects nothing.
    function automatic int po_of(int g, int c);
        case ({g[1:0], c[3:0]})
            6'h03: return 0;
            6'h07: return 9;
            6'h13: return 1;
            6'h14: return 2;
            6'h15: return 4;
            6'h23: return 1;
            6'h24: return 2;
            6'h25: return 6;
            6'h26: return 7;
            6'h27: return 10;
            6'h34: return 3;
            6'h35: return 5;
            6'h37: return 8;
            default: return -1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, 12'h05C, '0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h17C, '0);
        chk(rd, 32'h0);
        chk(PIN_REMAP_N, 32'hFFFFFFFF);
        apb(1'b1, 12'h000, 32'hFFFFFFFF);
        apb(1'b0, 12'h000, '0);
        chk(rd, 32'h0000000F);
        apb(1'b0, UNLOCK_KEY_OFFSET, '0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h300, '0);
        chk(er, 1'b1);
    endtask

    // Each input is swept over codes 0 to 8; for codes 0 to 7 the selected pin alone must decide its level, code 8 must give the idle level.
    task automatic t_inputs;
        int g;
        int p;
        for (int i = 0; i < NUM_IN; i++)
            for (int c = 0; c < 9; c++)
            begin
                g = (i < 5) ? 0 : (i < 11) ? 1 : (i < 19) ? 2 : 3;
                p = g * 8 + c;
                apb(1'b1, 12'(4 * i), 32'(c));
                level <= 32'h1 << p;
                cyc(4);
                chk(psi[i], (c < 8) ? 1'b1 : IN_IDLE[i]);
                level <= ~(32'h1 << p);
                cyc(4);
                chk(psi[i], (c < 8) ? 1'b0 : IN_IDLE[i]);
            end
    endtask

    task automatic t_outputs;
        int j;
        for (int p = 0; p < NUM_PINS; p++)
            for (int c = 0; c < 16; c++)
            begin
                j = po_of(p / 8, c);
                apb(1'b1, 12'(256 + 4 * p), 32'(c));
                po <= (j < 0) ? 11'h7FF : 11'h001 << j;
                cyc(2);
                chk({PIN_REMAP_N[p], PIN_OUT[p]}, (j < 0) ? 2'b10 : 2'b01);
                po <= (j < 0) ? 11'h000 : ~(11'h001 << j);
                cyc(2);
                chk({PIN_REMAP_N[p], PIN_OUT[p]}, (j < 0) ? 2'b10 : 2'b00);
            end
    endtask

    task automatic t_analog;
        apb(1'b1, OUT_SEL_BASE, 32'h3);
        apb(1'b1, IN_SEL_BASE, 32'h0);
        po <= 11'h001;
        level <= 32'h1;
        PIN_ANALOG <= 32'h1;
        cyc(4);
        chk({PIN_REMAP_N[0], PIN_OUT[0], psi[0]}, {2'b10, IN_IDLE[0]});
        PIN_ANALOG <= '0;
        cyc(4);
        chk({PIN_REMAP_N[0], PIN_OUT[0], psi[0]}, 3'b011);
    endtask

    // Run after a fused session too, so the lock reading clear shows what reset does.
    task automatic t_lock(input logic fuse);
        FUSE_CONFIG_BIT <= fuse;
        do_reset;
        apb(1'b0, DEV_CFG_OFFSET, '0);
        chk(rd[FUSE_BIT], fuse);
        apb(1'b1, CFG_CTRL_OFFSET, 32'h00002000);
        apb(1'b0, CFG_CTRL_OFFSET, '0);
        chk(rd[LOCK_BIT], 1'b0);
        set_lock(1'b1);
        apb(1'b0, CFG_CTRL_OFFSET, '0);
        chk(rd[LOCK_BIT], 1'b1);
        apb(1'b1, 12'h004, 32'h5);
        chk(er, 1'b0);
        apb(1'b0, 12'h004, '0);
        chk(rd, 32'h0);
        set_lock(1'b0);
        apb(1'b0, CFG_CTRL_OFFSET, '0);
        chk(rd[LOCK_BIT], fuse);
        apb(1'b1, 12'h004, 32'h5);
        apb(1'b0, 12'h004, '0);
        chk(rd, fuse ? 32'h0 : 32'h5);
    endtask

    initial
    begin
        do_reset;
        t_regs;
        t_inputs;
        t_outputs;
        t_analog;
        t_lock(1'b1);
        t_lock(1'b0);
        report_and_stop;
    end
endmodule
